// File: core/gyro_pkg.sv
package gyro_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int FIRST_BIT_DELAY_US = 20;
  localparam int FIRST_BIT_DELAY_CYC = FIRST_BIT_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int FRAME_GAP_US = 25;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int I2C_MAX_KBPS = 400;

  localparam logic [6:0] ADDR_MAIN = 7'h68;
  localparam logic [6:0] ADDR_ALT = 7'h69;
  localparam logic [7:0] I2C_RATE = 8'h25;
  localparam logic [7:0] I2C_TEMP = 8'h26;
  localparam logic [7:0] I2C_SELF_TEST_FAIL_FLAG = 8'h29;
  localparam logic [7:0] I2C_RST_FIRST = 8'h35;
  localparam logic [7:0] I2C_RST_LAST = 8'h39;
  localparam logic [2:0] I2C_SEQ_LAST = 3'h4;
  localparam logic [15:0] I2C_IDLE_WORD = 16'hffff;

  localparam logic [23:0] OP_RATE = 24'h482653;
  localparam logic [23:0] OP_TEMP = 24'h502a17;
  localparam logic [23:0] OP_RST1 = 24'h1c4e67;
  localparam logic [23:0] OP_RST2 = 24'h5c6e77;
  localparam logic [23:0] OP_CANCEL = 24'h044223;
  localparam logic [23:0] OP_NOP = 24'h301a0f;
  localparam logic [7:0] SYNC_BYTE = 8'h58;
  localparam logic [2:0] SPI_SEQ_LAST = 3'h6;
  localparam logic [4:0] SNAP_BIT = 5'h03;
  localparam logic [4:0] LAST_BIT = 5'h1f;

  localparam logic [2:0] K_NOP = 3'h0;
  localparam logic [2:0] K_RATE = 3'h1;
  localparam logic [2:0] K_TEMP = 3'h2;
  localparam logic [2:0] K_RST1 = 3'h3;
  localparam logic [2:0] K_RST2 = 3'h4;
  localparam logic [2:0] K_CANCEL = 3'h5;
  localparam logic [2:0] K_BAD = 3'h7;

  localparam logic [5:0] RC_RATE = 6'h12;
  localparam logic [5:0] RC_TEMP = 6'h14;
  localparam logic [5:0] RC_RST1 = 6'h07;
  localparam logic [5:0] RC_RST2 = 6'h17;
  localparam logic [5:0] RC_CANCEL = 6'h01;
  localparam logic [5:0] RC_NOP = 6'h00;

  typedef enum logic [7:0] {
    I_IDLE = 8'h01,
    I_ADDR = 8'h02,
    I_AACK = 8'h04,
    I_WR = 8'h08,
    I_WACK = 8'h10,
    I_RD = 8'h20,
    I_MACK = 8'h40,
    I_SKIP = 8'h80
  } i2c_state_t;

  function automatic logic [2:0] decode_op(input logic [23:0] op);
    case (op)
      OP_RATE: decode_op = K_RATE;
      OP_TEMP: decode_op = K_TEMP;
      OP_RST1: decode_op = K_RST1;
      OP_RST2: decode_op = K_RST2;
      OP_CANCEL: decode_op = K_CANCEL;
      OP_NOP: decode_op = K_NOP;
      default: decode_op = K_BAD;
    endcase
  endfunction : decode_op

  function automatic logic [5:0] kind_code(input logic [2:0] k);
    case (k)
      K_RATE: kind_code = RC_RATE;
      K_TEMP: kind_code = RC_TEMP;
      K_RST1: kind_code = RC_RST1;
      K_RST2: kind_code = RC_RST2;
      K_CANCEL: kind_code = RC_CANCEL;
      default: kind_code = RC_NOP;
    endcase
  endfunction : kind_code

  function automatic logic [2:0] seq_kind(input logic [2:0] idx);
    case (idx)
      3'h1: seq_kind = K_RST1;
      3'h2: seq_kind = K_RST2;
      3'h4: seq_kind = K_CANCEL;
      3'h7: seq_kind = K_BAD;
      default: seq_kind = K_NOP;
    endcase
  endfunction : seq_kind

  function automatic logic [4:0] checksum(input logic [26:0] v);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 27; i++) begin
      s = s + {4'h0, v[i]};
    end
    return s;
  endfunction : checksum
endpackage : gyro_pkg

// File: core/spi_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic req_tgl;
  logic [2:0] req_kind;
  logic reset_tgl;
  logic ack_tgl;
  logic snap_aru;
  logic [15:0] snap_data;
  logic self_test_fail_flag;
  logic sys_rst;
  modport link(output req_tgl, req_kind, reset_tgl,
    input ack_tgl, snap_aru, snap_data, self_test_fail_flag, sys_rst);
  modport core(input req_tgl, req_kind, reset_tgl,
    output ack_tgl, snap_aru, snap_data, self_test_fail_flag, sys_rst);
endinterface : spi_link_if
`default_nettype wire

// File: core/spi_frame_engine.sv
`timescale 1ns/100ps
`default_nettype none
module spi_frame_engine import gyro_pkg::*; (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  spi_link_if.link lnk
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] ss_sync;
    logic [1:0] self_test_fail_flag_sync;
    logic [1:0] ack_sync;
    logic [4:0] cnt;
    logic [31:0] shift;
    logic req_tgl;
    logic [2:0] kind;
    logic cef;
    logic self_test_fail_flag;
    logic rate_update_flag;
    logic [15:0] data;
    logic [2:0] seq;
    logic reset_tgl;
  } link_t;

  link_t st_reg, st_next;
  logic [26:0] body;
  logic [31:0] resp;

  assign body = {st_reg.cef, st_reg.self_test_fail_flag, 2'b00, st_reg.rate_update_flag,
    kind_code(st_reg.kind), st_reg.data};
  assign resp = {body[26:16], checksum(body), body[15:0]};
  assign lnk.req_tgl = st_reg.req_tgl;
  assign lnk.req_kind = st_reg.kind;
  assign lnk.reset_tgl = st_reg.reset_tgl;

  always_comb begin
    logic [2:0] k;
    logic bad;
    k = K_NOP;
    bad = 1'b0;
    st_next = st_reg;
    st_next.rst_sync = {st_reg.rst_sync[0], lnk.sys_rst};
    st_next.ss_sync = {st_reg.ss_sync[0], ss_n};
    st_next.self_test_fail_flag_sync = {st_reg.self_test_fail_flag_sync[0], lnk.self_test_fail_flag};
    st_next.ack_sync = {st_reg.ack_sync[0], lnk.ack_tgl};
    st_next.shift = {st_reg.shift[30:0], mosi};
    st_next.cnt = st_reg.cnt + 5'h01;
    // Core data is stable once the ack toggle has come back
    if (st_reg.cnt == SNAP_BIT && st_reg.ack_sync[1] == st_reg.req_tgl) begin
      st_next.rate_update_flag = lnk.snap_aru;
      st_next.data = lnk.snap_data;
    end
    if (st_reg.cnt == LAST_BIT) begin
      k = decode_op(st_reg.shift[30:7]);
      bad = (k == K_BAD) || ({st_reg.shift[6:0], mosi} != SYNC_BYTE);
      st_next.kind = bad ? K_BAD : k;
      st_next.cef = bad;
      st_next.self_test_fail_flag = st_reg.self_test_fail_flag_sync[1];
      st_next.rate_update_flag = 1'b0;
      st_next.data = 16'h0000;
      st_next.req_tgl = ~st_reg.req_tgl;
      if (!bad && k == seq_kind(st_reg.seq)) begin
        st_next.seq = (st_reg.seq == SPI_SEQ_LAST) ? 3'h0 : st_reg.seq + 3'h1;
        if (st_reg.seq == SPI_SEQ_LAST) begin
          st_next.reset_tgl = ~st_reg.reset_tgl;
        end
      end else begin
        st_next.seq = (!bad && k == K_NOP) ? 3'h1 : 3'h0;
      end
    end
    if (st_reg.rst_sync[1]) begin
      st_next.cnt = 5'h00;
      st_next.seq = 3'h0;
      st_next.cef = 1'b0;
      st_next.self_test_fail_flag = 1'b0;
      st_next.kind = K_NOP;
      st_next.rate_update_flag = 1'b0;
      st_next.data = 16'h0000;
      st_next.req_tgl = 1'b0;
      st_next.reset_tgl = 1'b0;
    end else if (st_reg.ss_sync[1]) begin
      st_next.cnt = 5'h00;
      st_next.seq = 3'h0;
    end
  end

  always_ff @(posedge sclk) begin
    st_reg <= st_next;
  end

  // Data leaves on the falling edge so the host samples on the rising one
  always_ff @(negedge sclk) begin
    if (st_reg.rst_sync[1]) begin
      miso <= 1'b0;
    end else begin
      miso <= resp[~st_reg.cnt];
    end
  end

  frame_len_a: assert property (@(posedge sclk) disable iff (st_reg.rst_sync[1])
    (st_reg.cnt == LAST_BIT && !st_reg.ss_sync[1]) |=> st_reg.cnt == 5'h00)
    else $error("frame not 32 bits");
  cef_sync_a: assert property (@(posedge sclk) disable iff (st_reg.rst_sync[1])
    (st_reg.cnt == LAST_BIT && !st_reg.ss_sync[1]
      && {st_reg.shift[6:0], mosi} != SYNC_BYTE) |=> st_reg.cef)
    else $error("bad sync byte not flagged");
  first_bit_a: assert property (@(posedge sclk) disable iff (st_reg.rst_sync[1])
    (st_reg.cnt == 5'h00 && $past(st_reg.cnt) == LAST_BIT) |-> miso == st_reg.cef)
    else $error("first response bit late");
  spi_reset_c: cover property (@(posedge sclk) $changed(st_reg.reset_tgl));
endmodule : spi_frame_engine
`default_nettype wire

// File: core/gyro_serial_command_port.sv
`timescale 1ns/100ps
`default_nettype none
module gyro_serial_command_port import gyro_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic sda_in,
  input wire logic i2c_mode,
  input wire logic alt_address,
  input wire logic [15:0] rate_data,
  input wire logic rate_new,
  input wire logic [10:0] temp_data,
  input wire logic self_test_fail,
  output logic spi_miso,
  output logic sda_out,
  output logic sda_oe,
  output logic logic_reset
);
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] req_s;
    logic [2:0] rst_s;
    logic ack_tgl;
    logic rate_update_flag;
    logic snap_aru;
    logic [15:0] snap_data;
    i2c_state_t state;
    logic [3:0] bits;
    logic [7:0] sh;
    logic dir;
    logic [15:0] rd_word;
    logic rd_last;
    logic [2:0] rseq;
    logic sda_oe;
    logic logic_reset;
  } core_t;

  core_t st_reg, st_next;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic cmd_done;
  logic i2c_rst_done;
  logic [6:0] own_addr;

  spi_link_if lnk ();

  spi_frame_engine spi_engine (
    .sclk(sclk),
    .ss_n(ss_n),
    .mosi(mosi),
    .miso(spi_miso),
    .lnk(lnk.link)
  );

  assign lnk.ack_tgl = st_reg.ack_tgl;
  assign lnk.snap_aru = st_reg.snap_aru;
  assign lnk.snap_data = st_reg.snap_data;
  assign lnk.self_test_fail_flag = self_test_fail;
  assign lnk.sys_rst = rst;

  // Stage 2 against stage 3; stage 1 only feeds stage 2
  assign scl_rise = st_reg.scl_s[1] & ~st_reg.scl_s[2];
  assign scl_fall = ~st_reg.scl_s[1] & st_reg.scl_s[2];
  assign start_seen = st_reg.scl_s[1] & st_reg.scl_s[2]
    & ~st_reg.sda_s[1] & st_reg.sda_s[2];
  assign stop_seen = st_reg.scl_s[1] & st_reg.scl_s[2]
    & st_reg.sda_s[1] & ~st_reg.sda_s[2];
  assign own_addr = alt_address ? ADDR_ALT : ADDR_MAIN;
  assign cmd_done = (st_reg.state == I_WR) && scl_fall && (st_reg.bits == 4'h8);
  assign i2c_rst_done = cmd_done && (st_reg.sh == I2C_RST_LAST)
    && (st_reg.rseq == I2C_SEQ_LAST);

  assign sda_out = 1'b0;
  assign sda_oe = st_reg.sda_oe;
  assign logic_reset = st_reg.logic_reset;

  always_comb begin
    st_next = st_reg;
    // Fast mode bit time spans over sixty clocks, so sampling keeps up
    st_next.scl_s = {st_reg.scl_s[1:0], sclk};
    st_next.sda_s = {st_reg.sda_s[1:0], sda_in};
    st_next.req_s = {st_reg.req_s[1:0], lnk.req_tgl};
    st_next.rst_s = {st_reg.rst_s[1:0], lnk.reset_tgl};
    st_next.logic_reset = 1'b0;

    // SPI snapshot; the kind is stable for a whole frame gap
    if (st_reg.req_s[1] ^ st_reg.req_s[2]) begin
      st_next.snap_aru = st_reg.rate_update_flag;
      st_next.ack_tgl = ~st_reg.ack_tgl;
      unique case (lnk.req_kind)
        K_RATE: begin
          st_next.snap_data = rate_data;
          st_next.rate_update_flag = 1'b0;
        end
        K_TEMP: st_next.snap_data = {5'h00, temp_data};
        default: st_next.snap_data = 16'h0000;
      endcase
    end
    if (st_reg.rst_s[1] ^ st_reg.rst_s[2]) begin
      st_next.logic_reset = 1'b1;
    end

    unique case (st_reg.state)
      I_IDLE: begin
      end
      I_ADDR: begin
        if (scl_rise) begin
          st_next.sh = {st_reg.sh[6:0], st_reg.sda_s[1]};
          st_next.bits = st_reg.bits + 4'h1;
        end else if (scl_fall && st_reg.bits == 4'h8) begin
          st_next.bits = 4'h0;
          if (st_reg.sh[7:1] == own_addr) begin
            st_next.state = I_AACK;
            st_next.sda_oe = 1'b1;
            st_next.dir = st_reg.sh[0];
          end else begin
            st_next.state = I_SKIP;
          end
        end
      end
      I_AACK: begin
        if (scl_fall) begin
          st_next.sda_oe = 1'b0;
          if (st_reg.dir) begin
            st_next.state = I_RD;
            st_next.sda_oe = ~st_reg.rd_word[15];
          end else begin
            st_next.state = I_WR;
          end
        end
      end
      I_WR: begin
        if (scl_rise) begin
          st_next.sh = {st_reg.sh[6:0], st_reg.sda_s[1]};
          st_next.bits = st_reg.bits + 4'h1;
        end else if (cmd_done) begin
          st_next.bits = 4'h0;
          st_next.state = I_WACK;
          st_next.sda_oe = 1'b1;
          st_next.rd_word = I2C_IDLE_WORD;
          st_next.rd_last = 1'b1;
          unique case (st_reg.sh)
            I2C_RATE: begin
              st_next.rd_word = rate_data;
              st_next.rd_last = 1'b0;
              st_next.rate_update_flag = 1'b0;
            end
            I2C_TEMP: begin
              st_next.rd_word = {5'h00, temp_data};
              st_next.rd_last = 1'b0;
            end
            I2C_SELF_TEST_FAIL_FLAG: st_next.rd_word = {2'b00, self_test_fail, 13'h1fff};
            default: begin
            end
          endcase
          // Reset commands leave the idle word so a read sees nothing
          if (st_reg.sh == I2C_RST_FIRST + {5'h00, st_reg.rseq}) begin
            st_next.rseq = i2c_rst_done ? 3'h0 : st_reg.rseq + 3'h1;
          end else begin
            st_next.rseq = (st_reg.sh == I2C_RST_FIRST) ? 3'h1 : 3'h0;
          end
          if (i2c_rst_done) begin
            st_next.logic_reset = 1'b1;
          end
        end
      end
      I_WACK: begin
        if (scl_fall) begin
          st_next.sda_oe = 1'b0;
          st_next.state = I_WR;
        end
      end
      I_RD: begin
        if (scl_fall) begin
          st_next.bits = st_reg.bits + 4'h1;
          st_next.rd_word = {st_reg.rd_word[14:0], 1'b0};
          if (st_reg.bits == 4'h7) begin
            st_next.state = I_MACK;
            st_next.sda_oe = 1'b0;
          end else begin
            st_next.sda_oe = ~st_reg.rd_word[14];
          end
        end
      end
      I_MACK: begin
        // Direction bit is reused to hold the host's acknowledge level
        if (scl_rise) begin
          st_next.dir = st_reg.sda_s[1];
        end else if (scl_fall) begin
          if (!st_reg.dir && !st_reg.rd_last) begin
            st_next.state = I_RD;
            st_next.bits = 4'h0;
            st_next.rd_last = 1'b1;
            st_next.sda_oe = ~st_reg.rd_word[15];
          end else begin
            st_next.state = I_SKIP;
          end
        end
      end
      I_SKIP: begin
      end
      default: st_next.state = I_IDLE;
    endcase

    if (start_seen) begin
      st_next.state = i2c_mode ? I_ADDR : I_IDLE;
      st_next.bits = 4'h0;
      st_next.sda_oe = 1'b0;
    end
    if (stop_seen) begin
      st_next.state = I_IDLE;
      st_next.sda_oe = 1'b0;
    end
    if (st_next.logic_reset) begin
      st_next.rseq = 3'h0;
      st_next.rate_update_flag = 1'b0;
    end
    // New data outranks a clear in the same cycle
    if (rate_new) begin
      st_next.rate_update_flag = 1'b1;
    end
    if (rst) begin
      st_next = '0;
      st_next.state = I_IDLE;
      st_next.rd_word = I2C_IDLE_WORD;
      st_next.rd_last = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  stop_idle_a: assert property (stop_seen |=> st_reg.state == I_IDLE)
    else $error("stop did not return to idle");
  skip_quiet_a: assert property (st_reg.state == I_SKIP |-> !st_reg.sda_oe)
    else $error("data driven for foreign address");
  addr_ack_a: assert property ((st_reg.state == I_ADDR && scl_fall
      && st_reg.bits == 4'h8 && st_reg.sh[7:1] == own_addr && !start_seen
      && !stop_seen) |=> st_reg.sda_oe && st_reg.state == I_AACK)
    else $error("own address not acknowledged");
  dir_read_a: assert property ((st_reg.state == I_AACK && scl_fall
      && st_reg.dir && !start_seen && !stop_seen) |=> st_reg.state == I_RD)
    else $error("read bit did not start a read");
  byte_len_a: assert property ((st_reg.state == I_RD && scl_fall
      && st_reg.bits == 4'h7 && !start_seen && !stop_seen)
      |=> st_reg.state == I_MACK && !st_reg.sda_oe)
    else $error("read byte not eight bits");
  reset_pulse_a: assert property (i2c_rst_done
      |=> st_reg.logic_reset ##1 (!st_reg.logic_reset || $past(st_reg.rst_s[1])
      != $past(st_reg.rst_s[2])))
    else $error("reset series gave no pulse");
  aru_set_a: assert property (rate_new |=> st_reg.rate_update_flag)
    else $error("update flag lost");
  temp_word_a: assert property ((cmd_done && st_reg.sh == I2C_TEMP)
      |=> st_reg.rd_word == {5'h00, $past(temp_data)})
    else $error("temperature word wrong");
  rate_word_a: assert property ((cmd_done && st_reg.sh == I2C_RATE)
      |=> st_reg.rd_word == $past(rate_data))
    else $error("rate word wrong");
  self_test_fail_flag_word_a: assert property ((cmd_done && st_reg.sh == I2C_SELF_TEST_FAIL_FLAG)
      |=> st_reg.rd_word[15:13] == {2'b00, $past(self_test_fail)})
    else $error("self-test byte wrong");

  read_two_c: cover property (st_reg.state == I_MACK ##[1:200] st_reg.state == I_RD);
  foreign_c: cover property (st_reg.state == I_ADDR ##1 st_reg.state == I_SKIP);
  reset_c: cover property (i2c_rst_done ##1 st_reg.logic_reset);
endmodule : gyro_serial_command_port
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model import gyro_pkg::*; (
  output var logic sclk,
  output var logic ss_n,
  output var logic mosi,
  output var logic sda_low,
  input wire logic miso,
  input wire logic sda
);
  localparam int SPI_HALF = 80;
  // Quarter of a 400 kHz bit time
  localparam int SCL_Q = 625;

  // Clock and select come from the flush, which the bench runs at time zero
  initial begin
    mosi = 1'b0;
    sda_low = 1'b0;
  end

  // Select high realigns the bit count; two more edges with select low
  // let the engine's synchroniser see the low level before a frame starts
  task automatic spi_flush();
    ss_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i == 3) ss_n = 1'b0;
      sclk = 1'b0;
      #SPI_HALF sclk = 1'b1;
      #SPI_HALF;
    end
  endtask : spi_flush

  task automatic use_i2c();
    ss_n = 1'b1;
  endtask : use_i2c

  task automatic spi_frame(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = cmd[i];
      #SPI_HALF sclk = 1'b1;
      rsp[i] = miso;
      #SPI_HALF;
    end
    // Clock parks high; stale data must not look valid
    mosi = ~mosi;
    #(FRAME_GAP_US * 1000);
  endtask : spi_frame

  task automatic i2c_start();
    sda_low = 1'b0;
    #SCL_Q sclk = 1'b1;
    #(2 * SCL_Q) sda_low = 1'b1;
    #(2 * SCL_Q) sclk = 1'b0;
    #SCL_Q;
  endtask : i2c_start

  task automatic i2c_bit(input logic b, output logic r);
    sda_low = ~b;
    #SCL_Q sclk = 1'b1;
    #SCL_Q r = sda;
    #SCL_Q sclk = 1'b0;
    #SCL_Q;
  endtask : i2c_bit

  task automatic i2c_byte(input logic [7:0] wb, input logic ack_in, output logic [7:0] rb,
    output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(wb[i], rb[i]);
    end
    i2c_bit(ack_in, ack_out);
  endtask : i2c_byte

  task automatic i2c_stop();
    sda_low = 1'b1;
    #SCL_Q sclk = 1'b1;
    #SCL_Q sda_low = 1'b0;
    #(2 * SCL_Q);
  endtask : i2c_stop

  task automatic i2c_xfer(input logic [6:0] addr, input logic [7:0] cmd, input int n,
    output logic ok, output logic [15:0] d);
    logic [7:0] rb;
    logic a;
    ok = 1'b1;
    d = 16'h0000;
    i2c_start();
    i2c_byte({addr, 1'b0}, 1'b1, rb, a);
    ok &= ~a;
    i2c_byte(cmd, 1'b1, rb, a);
    ok &= ~a;
    if (n > 0) begin
      i2c_start();
      i2c_byte({addr, 1'b1}, 1'b1, rb, a);
      ok &= ~a;
      for (int k = n; k > 0; k--) begin
        i2c_byte(8'hff, k == 1, rb, a);
        d = {d[7:0], rb};
      end
    end
    i2c_stop();
  endtask : i2c_xfer
endmodule : host_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb;
  import gyro_pkg::*;
  logic clock, rst, i2c_mode, alt_address, rate_new, self_test_fail;
  logic [15:0] rate_data;
  logic [10:0] temp_data;
  logic sclk, ss_n, mosi, sda_low, spi_miso, sda_out, sda_oe, logic_reset, sda_wire, ok;
  logic [31:0] rsp;
  logic [15:0] d;
  int n_fail = 0;
  int cmp_count = 0;
  int n_resets = 0;

  // Open drain wire with pull-up
  assign sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);

  gyro_serial_command_port dut (.clock(clock), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .sda_in(sda_wire), .i2c_mode(i2c_mode), .alt_address(alt_address), .rate_data(rate_data),
    .rate_new(rate_new), .temp_data(temp_data), .self_test_fail(self_test_fail),
    .spi_miso(spi_miso), .sda_out(sda_out), .sda_oe(sda_oe), .logic_reset(logic_reset));
  host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .sda_low(sda_low), .miso(spi_miso),
    .sda(sda_wire));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Counts high cycles, so a clean pulse adds exactly one
  always @(posedge clock) begin
    if (logic_reset === 1'b1) n_resets++;
  end

  function automatic logic [31:0] resp_exp(input logic cef, input logic rate_update_flag,
    input logic [5:0] code, input logic [15:0] dat);
    logic [26:0] v;
    logic [4:0] s;
    v = {cef, self_test_fail, 2'b00, rate_update_flag, code, dat};
    s = 5'h00;
    foreach (v[i]) s = s + 5'(v[i]);
    return {v[26:16], s, v[15:0]};
  endfunction : resp_exp

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic test_spi_data();
    host.spi_frame({OP_NOP, SYNC_BYTE}, rsp);
    @(negedge clock) rate_new = 1'b1;
    @(negedge clock) rate_new = 1'b0;
    host.spi_frame({OP_RATE, SYNC_BYTE}, rsp);
    host.spi_frame({OP_TEMP, SYNC_BYTE}, rsp);
    `CHECK(rsp, resp_exp(1'b0, 1'b1, RC_RATE, rate_data))
    host.spi_frame({OP_RATE, SYNC_BYTE}, rsp);
    `CHECK(rsp, resp_exp(1'b0, 1'b0, RC_TEMP, {5'h00, temp_data}))
    host.spi_frame({OP_NOP, SYNC_BYTE}, rsp);
    `CHECK(rsp, resp_exp(1'b0, 1'b0, RC_RATE, rate_data))
  endtask : test_spi_data

  task automatic test_spi_error();
    host.spi_frame(32'h12345658, rsp);
    host.spi_frame({OP_RATE, 8'h00}, rsp);
    `CHECK(rsp, resp_exp(1'b1, 1'b0, RC_NOP, 16'h0000))
    host.spi_frame({OP_NOP, SYNC_BYTE}, rsp);
    `CHECK(rsp, resp_exp(1'b1, 1'b0, RC_NOP, 16'h0000))
  endtask : test_spi_error

  task automatic test_spi_reset();
    logic [23:0] ops [7] = '{OP_NOP, OP_RST1, OP_RST2, OP_NOP, OP_CANCEL, OP_NOP, OP_NOP};
    logic [5:0] prev [7] = '{RC_NOP, RC_NOP, RC_RST1, RC_RST2, RC_NOP, RC_CANCEL, RC_NOP};
    int n0;
    n0 = n_resets;
    foreach (ops[i]) begin
      host.spi_frame({ops[i], SYNC_BYTE}, rsp);
      `CHECK(rsp, resp_exp(1'b0, 1'b0, prev[i], 16'h0000))
      if (i == 5) `CHECK(n_resets, n0)
    end
    `CHECK(n_resets, n0 + 1)
    // Design does not gate commands after reset; a short pause stands in
    repeat (100) @(negedge clock);
  endtask : test_spi_reset

  task automatic test_i2c_read();
    @(negedge clock) i2c_mode = 1'b1;
    repeat (8) @(negedge clock);
    host.i2c_xfer(ADDR_MAIN, I2C_TEMP, 2, ok, d);
    `CHECK(ok, 1'b1)
    `CHECK(d, {5'h00, temp_data})
    host.i2c_xfer(ADDR_MAIN, I2C_RATE, 2, ok, d);
    `CHECK(d, rate_data)
    host.i2c_xfer(ADDR_MAIN, I2C_SELF_TEST_FAIL_FLAG, 1, ok, d);
    `CHECK(d[7:5], {2'b00, self_test_fail})
  endtask : test_i2c_read

  task automatic test_i2c_addr();
    @(negedge clock) alt_address = 1'b1;
    host.i2c_xfer(ADDR_MAIN, I2C_RATE, 2, ok, d);
    `CHECK(ok, 1'b0)
    `CHECK(d, 16'hffff)
    // Fresh value shows the answer is taken at command time
    @(negedge clock) rate_data = 16'h7ffe;
    host.i2c_xfer(ADDR_ALT, I2C_RATE, 2, ok, d);
    `CHECK(ok, 1'b1)
    `CHECK(d, rate_data)
    @(negedge clock) alt_address = 1'b0;
  endtask : test_i2c_addr

  task automatic test_i2c_reset();
    int n0;
    n0 = n_resets;
    for (int c = 0; c < 5; c++) begin
      if (c == 4) `CHECK(n_resets, n0)
      host.i2c_xfer(ADDR_MAIN, I2C_RST_FIRST + 8'(c), 0, ok, d);
      `CHECK(ok, 1'b1)
    end
    `CHECK(n_resets, n0 + 1)
    // Design does not gate commands after reset; a short pause stands in
    repeat (100) @(negedge clock);
  endtask : test_i2c_reset

  initial begin
    rst = 1'b1;
    i2c_mode = 1'b0;
    alt_address = 1'b0;
    rate_data = 16'h8001;
    rate_new = 1'b0;
    temp_data = 11'h4a5;
    self_test_fail = 1'b1;
    // Link side needs its own edges to see the reset
    fork
      host.spi_flush();
      repeat (20) @(negedge clock);
    join
    rst = 1'b0;
    repeat (4) @(negedge clock);
    // Engine reset synchroniser drains only on link edges
    host.spi_flush();
    test_spi_data();
    test_spi_error();
    test_spi_reset();
    host.use_i2c();
    test_i2c_read();
    test_i2c_addr();
    test_i2c_reset();
    stop_test();
  end

  // Whole run needs about 1.3 ms
  initial begin
    #3_000_000;
    n_fail++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
